// File: orm_pkg.sv
// Package with the constants and types of the option and remap block.
// How it works
// - Low bank bit selects RAM or ROM window
// - Upper bank bit selects RAM or ROM window
// - Sensitivity bit picks edge-and-level or edge-only
// - Sensitivity set at reset, first write only
// - Sensitivity applies to pin and port B
// - Internal clock is oscillator divided by two
// - Low reset pin resets the device
// - Device drives reset pin on internal reset
// - All port pins are inputs during reset
// - Port D has seven lines, bit six absent
// - Per-pin port B interrupt and pull-up option
// - Option register sits at index 3fdf
package orm_pkg;

  // Clock and timing.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RST_PULSE_NS  = 1000;
  localparam int unsigned RST_PULSE_CYC =
    (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  RST_CNT_LOAD  = 8'(RST_PULSE_CYC);
  localparam logic [2:0]  PIN_GUARD     = 3'h7;

  // Register indices; byte address is four times the index.
  localparam logic [13:0] IDX_PORT_A_DATA = 14'h0000;
  localparam logic [13:0] IDX_PORT_B_DATA = 14'h0001;
  localparam logic [13:0] IDX_PORT_C_DATA = 14'h0002;
  localparam logic [13:0] IDX_PORT_D_DATA = 14'h0003;
  localparam logic [13:0] IDX_PORT_A_DIR  = 14'h0004;
  localparam logic [13:0] IDX_PORT_B_DIR  = 14'h0005;
  localparam logic [13:0] IDX_PORT_C_DIR  = 14'h0006;
  localparam logic [13:0] IDX_PORT_D_DIR  = 14'h0007;
  localparam logic [13:0] IDX_OPTION      = 14'h3fdf;
  localparam logic [13:0] IDX_INT_STATUS  = 14'h3fe0;
  localparam logic [13:0] IDX_INT_MASK    = 14'h3fe1;

  // Banked memory windows.
  localparam logic [13:0] LOW_WIN_FIRST = 14'h0020;
  localparam logic [13:0] LOW_WIN_LAST  = 14'h004f;
  localparam logic [13:0] UP_WIN_FIRST  = 14'h0100;
  localparam logic [13:0] UP_WIN_LAST   = 14'h017f;
  localparam logic [7:0]  LOW_WIN_SIZE  = 8'h30;
  localparam int unsigned RAM_DEPTH     = 176;
  localparam logic [7:0]  ROM_FILL      = 8'hff;

  // Option register fields and reset value.
  localparam int unsigned OPT_LOW_BANK_BIT = 0;
  localparam int unsigned OPT_UP_BANK_BIT  = 1;
  localparam int unsigned OPT_SENS_BIT     = 7;
  localparam logic [7:0]  OPT_RESET        = 8'h80;

  // Interrupt status fields and reset values.
  localparam int unsigned ST_IRQ_PIN_BIT = 0;
  localparam int unsigned ST_PORT_B_BIT  = 1;
  localparam int unsigned ST_RESET_BIT   = 2;
  localparam logic [7:0]  ST_USED_MASK   = 8'h07;
  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam logic [7:0]  MASK_RESET     = 8'h00;

  // Port reset values and implemented lines.
  localparam logic [7:0]  DIR_RESET   = 8'h00;
  localparam logic [7:0]  DATA_RESET  = 8'h00;
  localparam logic [7:0]  PORT_D_MASK = 8'hbf;

  // APB request from the master.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } orm_apb_req_t;

  // Window decode result.
  typedef struct packed {
    logic       win;
    logic       ram;
    logic [7:0] ram_addr;
  } orm_win_t;

endpackage

// File: orm_ram.sv
// Small byte memory holding both banked RAM windows.
`timescale 1ns/1ns
module orm_ram
  import orm_pkg::*;
(
  // Clock.
  input  wire logic       clk_sys,
  // Access.
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data
);

  logic [7:0] mem [0:RAM_DEPTH-1];

  // Write port; contents are not cleared by reset.
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
  end

  // Registered read port.
  always_ff @(posedge clk_sys) begin
    if (rd_en) begin
      rd_data <= mem[addr];
    end
  end

endmodule

// File: orm_top.sv
// Option register, memory remap, interrupt sense, reset pin and ports.
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ns
module orm_top
  import orm_pkg::*;
#(
  parameter logic [7:0] PB_IRQ_OPT = 8'h00
)(
  // Clock and reset.
  input  wire logic         clk_sys,
  input  wire logic         srst,
  // APB slave.
  input  wire orm_apb_req_t apb_req,
  output logic              pready,
  output logic       [31:0] prdata,
  output logic              pslverr,
  // Interrupt and internal clock phase.
  output logic              irq_out,
  output logic              cpu_clk_en,
  // External interrupt pin and internal reset source.
  input  wire logic         irq_pin_n,
  input  wire logic         int_reset_req,
  // Reset pin.
  input  wire logic         reset_pin_n_in,
  output logic              reset_pin_n_out,
  output logic              reset_pin_oe,
  // Port A.
  input  wire logic  [7:0]  port_a_lines_in,
  output logic       [7:0]  port_a_lines_out,
  output logic       [7:0]  port_a_lines_oe,
  // Port B.
  input  wire logic  [7:0]  port_b_lines_in,
  output logic       [7:0]  port_b_lines_out,
  output logic       [7:0]  port_b_lines_oe,
  output logic       [7:0]  port_b_pullup_en,
  // Port C.
  input  wire logic  [7:0]  port_c_lines_in,
  output logic       [7:0]  port_c_lines_out,
  output logic       [7:0]  port_c_lines_oe,
  // Port D.
  input  wire logic  [5:0]  port_d_low_lines_in,
  output logic       [5:0]  port_d_low_lines_out,
  output logic       [5:0]  port_d_low_lines_oe,
  input  wire logic         port_d_top_line_in,
  output logic              port_d_top_line_out,
  output logic              port_d_top_line_oe
);

  // Maps an index onto the banked windows and the RAM address.
  function automatic orm_win_t win_map(input logic [13:0] idx,
                                       input logic [7:0]  opt);
    orm_win_t w;
    w = '0;
    if (idx >= LOW_WIN_FIRST && idx <= LOW_WIN_LAST) begin
      w.win      = 1'b1;
      w.ram      = opt[OPT_LOW_BANK_BIT];
      w.ram_addr = 8'(idx - LOW_WIN_FIRST);
    end else if (idx >= UP_WIN_FIRST && idx <= UP_WIN_LAST) begin
      w.win      = 1'b1;
      w.ram      = opt[OPT_UP_BANK_BIT];
      w.ram_addr = 8'(idx - UP_WIN_FIRST) + LOW_WIN_SIZE;
    end
    return w;
  endfunction

  // Input synchroniser stages: irq, reset pin, ports A to D.
  logic [33:0] sync_meta_r;
  logic [33:0] sync_r;
  logic        irq_s;
  logic        rst_pin_s;
  logic [7:0]  pa_s;
  logic [7:0]  pb_s;
  logic [7:0]  pc_s;
  logic [7:0]  pd_s;

  // Reset control.
  logic       rst_req_r;
  logic       rst_any;
  logic [7:0] drive_cnt_r;
  logic [7:0] drive_cnt_nxt;
  logic [2:0] guard_r;
  logic       ext_low;

  // Register state.
  logic [7:0] opt_r;
  logic       sens_locked_r;
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] mask_r;
  logic [7:0] dir_a_r;
  logic [7:0] dir_b_r;
  logic [7:0] dir_c_r;
  logic [7:0] dir_d_r;
  logic [7:0] dat_a_r;
  logic [7:0] dat_b_r;
  logic [7:0] dat_c_r;
  logic [7:0] dat_d_r;

  // Interrupt detection.
  logic       irq_prev_r;
  logic [7:0] pb_prev_r;
  logic       boot_r;
  logic       phase_r;
  logic       ev_pin;
  logic       ev_pb;
  logic       sens;

  // Bus decode.
  logic [13:0] idx;
  logic        setup;
  logic        access;
  logic        commit;
  logic        wr_commit;
  logic        rd_commit;
  orm_win_t    win;
  logic [7:0]  ram_rd;
  logic [7:0]  rd_val;
  logic        rd_hit;
  logic [7:0]  wbyte;

  // Two flip-flops on every pin before any logic reads it.
  always_ff @(posedge clk_sys) begin
    sync_meta_r <= {irq_pin_n, reset_pin_n_in, port_a_lines_in,
                    port_b_lines_in, port_c_lines_in, port_d_top_line_in,
                    1'b0, port_d_low_lines_in};
    sync_r      <= sync_meta_r;
  end

  assign irq_s     = sync_r[33];
  assign rst_pin_s = sync_r[32];
  assign pa_s      = sync_r[31:24];
  assign pb_s      = sync_r[23:16];
  assign pc_s      = sync_r[15:8];
  assign pd_s      = sync_r[7:0] & PORT_D_MASK;

  // External low on the pin resets us, but not our own drive echo.
  assign ext_low = ~rst_pin_s & (guard_r == 3'h0);
  assign rst_any = srst | rst_req_r;

  // Reset request from the pin or an internal source.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rst_req_r <= 1'b0;
    end else begin
      rst_req_r <= ext_low | int_reset_req;
    end
  end

  // Pulse length while the device drives its reset pin low.
  always_comb begin
    drive_cnt_nxt = drive_cnt_r;
    if (srst || int_reset_req) begin
      drive_cnt_nxt = RST_CNT_LOAD;
    end else if (drive_cnt_r != 8'h00) begin
      drive_cnt_nxt = drive_cnt_r - 8'h01;
    end
  end

  // Reset pin drive and echo guard.
  always_ff @(posedge clk_sys) begin
    drive_cnt_r     <= drive_cnt_nxt;
    reset_pin_n_out <= 1'b0;
    reset_pin_oe    <= (drive_cnt_nxt != 8'h00);
    if (drive_cnt_r != 8'h00) begin
      guard_r <= PIN_GUARD;
    end else if (guard_r != 3'h0) begin
      guard_r <= guard_r - 3'h1;
    end
  end

  // Internal operating clock as an enable at half the input rate.
  always_ff @(posedge clk_sys) begin
    if (rst_any) begin
      phase_r    <= 1'b0;
      cpu_clk_en <= 1'b0;
    end else begin
      phase_r    <= ~phase_r;
      cpu_clk_en <= ~phase_r;
    end
  end

  // APB phases and write data.
  assign idx       = apb_req.paddr[15:2];
  assign setup     = apb_req.psel & ~apb_req.penable;
  assign access    = apb_req.psel & apb_req.penable;
  assign commit    = access & pready;
  assign wr_commit = commit & apb_req.pwrite;
  assign rd_commit = commit & ~apb_req.pwrite;
  assign wbyte     = apb_req.pwdata[7:0];
  assign win       = win_map(idx, opt_r);

  // Banked RAM behind both windows.
  orm_ram u_ram (
    .clk_sys (clk_sys),
    .wr_en   (wr_commit & win.win & win.ram),
    .rd_en   (setup & win.win & win.ram),
    .addr    (win.ram_addr),
    .wr_data (wbyte),
    .rd_data (ram_rd)
  );

  // Read data selection and address check.
  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    if (win.win) begin
      rd_val = win.ram ? ram_rd : ROM_FILL;
    end else begin
      case (idx)
        IDX_PORT_A_DATA: rd_val = (dir_a_r & dat_a_r) | (~dir_a_r & pa_s);
        IDX_PORT_B_DATA: rd_val = (dir_b_r & dat_b_r) | (~dir_b_r & pb_s);
        IDX_PORT_C_DATA: rd_val = (dir_c_r & dat_c_r) | (~dir_c_r & pc_s);
        IDX_PORT_D_DATA: rd_val = ((dir_d_r & dat_d_r) | (~dir_d_r & pd_s))
                                  & PORT_D_MASK;
        IDX_PORT_A_DIR:  rd_val = dir_a_r;
        IDX_PORT_B_DIR:  rd_val = dir_b_r;
        IDX_PORT_C_DIR:  rd_val = dir_c_r;
        IDX_PORT_D_DIR:  rd_val = dir_d_r;
        IDX_OPTION:      rd_val = opt_r;
        IDX_INT_STATUS:  rd_val = status_r;
        IDX_INT_MASK:    rd_val = mask_r;
        default:         rd_hit = 1'b0;
      endcase
    end
  end

  // One wait state; answer registered in the first access cycle.
  always_ff @(posedge clk_sys) begin
    if (rst_any) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access & ~pready;
      prdata  <= (access & ~pready & ~apb_req.pwrite) ?
                 {24'h00_0000, rd_val} : 32'h0000_0000;
      pslverr <= access & ~pready & ~rd_hit;
    end
  end

  // Option register: banks always writable, sensitivity written once.
  always_ff @(posedge clk_sys) begin
    if (rst_any) begin
      opt_r         <= OPT_RESET;
      sens_locked_r <= 1'b0;
    end else if (wr_commit && idx == IDX_OPTION) begin
      opt_r[OPT_LOW_BANK_BIT] <= wbyte[OPT_LOW_BANK_BIT];
      opt_r[OPT_UP_BANK_BIT]  <= wbyte[OPT_UP_BANK_BIT];
      if (!sens_locked_r) begin
        opt_r[OPT_SENS_BIT] <= wbyte[OPT_SENS_BIT];
      end
      sens_locked_r <= 1'b1;
    end
  end

  // Port direction and data latches; all inputs after reset.
  always_ff @(posedge clk_sys) begin
    if (rst_any) begin
      dir_a_r <= DIR_RESET;
      dir_b_r <= DIR_RESET;
      dir_c_r <= DIR_RESET;
      dir_d_r <= DIR_RESET;
      dat_a_r <= DATA_RESET;
      dat_b_r <= DATA_RESET;
      dat_c_r <= DATA_RESET;
      dat_d_r <= DATA_RESET;
    end else if (wr_commit) begin
      case (idx)
        IDX_PORT_A_DATA: dat_a_r <= wbyte;
        IDX_PORT_B_DATA: dat_b_r <= wbyte;
        IDX_PORT_C_DATA: dat_c_r <= wbyte;
        IDX_PORT_D_DATA: dat_d_r <= wbyte & PORT_D_MASK;
        IDX_PORT_A_DIR:  dir_a_r <= wbyte;
        IDX_PORT_B_DIR:  dir_b_r <= wbyte;
        IDX_PORT_C_DIR:  dir_c_r <= wbyte;
        IDX_PORT_D_DIR:  dir_d_r <= wbyte & PORT_D_MASK;
        default: ;
      endcase
    end
  end

  // Port pin drivers follow the latches.
  assign port_a_lines_out     = dat_a_r;
  assign port_a_lines_oe      = dir_a_r;
  assign port_b_lines_out     = dat_b_r;
  assign port_b_lines_oe      = dir_b_r;
  assign port_c_lines_out     = dat_c_r;
  assign port_c_lines_oe      = dir_c_r;
  assign port_d_low_lines_out = dat_d_r[5:0];
  assign port_d_low_lines_oe  = dir_d_r[5:0];
  assign port_d_top_line_out  = dat_d_r[7];
  assign port_d_top_line_oe   = dir_d_r[7];

  // Pull-ups exist only on pins built with the interrupt option.
  always_ff @(posedge clk_sys) begin
    port_b_pullup_en <= PB_IRQ_OPT;
  end

  // Previous levels for falling-edge detection.
  always_ff @(posedge clk_sys) begin
    if (rst_any) begin
      irq_prev_r <= 1'b1;
      pb_prev_r  <= 8'hff;
      boot_r     <= 1'b1;
    end else begin
      irq_prev_r <= irq_s;
      pb_prev_r  <= pb_s;
      boot_r     <= 1'b0;
    end
  end

  // Edge-only latches a fall; edge-and-level also holds while low.
  assign sens   = opt_r[OPT_SENS_BIT];
  assign ev_pin = sens ? ~irq_s : (irq_prev_r & ~irq_s);
  assign ev_pb  = |(PB_IRQ_OPT & (sens ? ~pb_s
                                       : (pb_prev_r & ~pb_s)));

  // Sticky status; a read clears it but a new event wins.
  always_comb begin
    status_nxt = status_r;
    if (rd_commit && idx == IDX_INT_STATUS) begin
      status_nxt = STATUS_RESET;
    end
    status_nxt[ST_IRQ_PIN_BIT] = status_nxt[ST_IRQ_PIN_BIT] | ev_pin;
    status_nxt[ST_PORT_B_BIT]  = status_nxt[ST_PORT_B_BIT] | ev_pb;
    status_nxt[ST_RESET_BIT]   = status_nxt[ST_RESET_BIT] | boot_r;
  end

  // Status, mask and the interrupt line.
  always_ff @(posedge clk_sys) begin
    if (rst_any) begin
      status_r <= STATUS_RESET;
      mask_r   <= MASK_RESET;
      irq_out  <= 1'b0;
    end else begin
      status_r <= status_nxt;
      if (wr_commit && idx == IDX_INT_MASK) begin
        mask_r <= wbyte & ST_USED_MASK;
      end
      irq_out <= |(status_nxt & mask_r);
    end
  end

endmodule

// File: orm_properties.sv
// Port checker for the option and remap block.
`timescale 1ns/1ns
module orm_checker
  import orm_pkg::*;
#(
  parameter logic [7:0] PB_IRQ_OPT = 8'h00
)(
  // Clock and reset sources.
  input wire logic         clk_sys,
  input wire logic         srst,
  input wire logic         int_reset_req,
  input wire logic         reset_pin_n_in,
  input wire logic         reset_pin_n_out,
  input wire logic         reset_pin_oe,
  // Register bus.
  input wire orm_apb_req_t apb_req,
  input wire logic         pready,
  input wire logic         pslverr,
  // Outputs under watch.
  input wire logic         irq_out,
  input wire logic         cpu_clk_en,
  input wire logic  [7:0]  port_a_lines_oe,
  input wire logic  [7:0]  port_b_lines_oe,
  input wire logic  [7:0]  port_b_pullup_en
);
  logic [3:0] quiet_r;

  default clocking cb @(posedge clk_sys);
  endclocking

  // Holds steady-state checks off for a while after any reset cause.
  always_ff @(posedge clk_sys) begin
    if (srst || int_reset_req || reset_pin_oe || !reset_pin_n_in) begin
      quiet_r <= 4'hf;
    end else if (quiet_r != 4'h0) begin
      quiet_r <= quiet_r - 4'h1;
    end
  end

  // Bus answers, clock phase, reset pin and port defaults.
  a_ready_single: assert property (
    disable iff (srst) pready |=> !pready)
    else $error("pready stood longer than one cycle");
  a_ready_access: assert property (
    disable iff (srst) pready |->
      apb_req.psel && apb_req.penable && $past(apb_req.penable))
    else $error("pready outside an access phase");
  a_option_mapped: assert property (
    disable iff (srst) pready && apb_req.paddr[15:2] == IDX_OPTION
      |-> !pslverr)
    else $error("option register refused");
  a_clk_halved: assert property (
    disable iff (srst || quiet_r != 4'h0) cpu_clk_en != $past(cpu_clk_en))
    else $error("internal clock enable did not toggle");
  a_ports_reset: assert property (
    disable iff (srst) $fell(srst) |-> port_a_lines_oe == 8'h00 &&
      port_b_lines_oe == 8'h00 && !pready && !irq_out)
    else $error("outputs not idle after reset");
  a_pin_drive: assert property (
    disable iff (srst) int_reset_req |-> ##[1:2] reset_pin_oe)
    else $error("reset pin not driven on internal reset");
  a_pin_low: assert property (
    disable iff (srst) reset_pin_oe |-> !reset_pin_n_out)
    else $error("reset pin driven high");
  a_int_reset_ports: assert property (
    disable iff (srst) $rose(reset_pin_oe) |->
      ##[0:2] (port_a_lines_oe == 8'h00 && !irq_out))
    else $error("ports not inputs in internal reset");
  a_pullup_opt: assert property (
    disable iff (srst || quiet_r != 4'h0) port_b_pullup_en == PB_IRQ_OPT)
    else $error("pull-up enables differ from option");

  // Main scenarios seen.
  cover property (pready && pslverr);
  cover property ($rose(irq_out));
  cover property ($rose(reset_pin_oe));
endmodule

bind orm_top orm_checker #(.PB_IRQ_OPT(PB_IRQ_OPT)) u_chk (
  .clk_sys(clk_sys), .srst(srst), .int_reset_req(int_reset_req),
  .reset_pin_n_in(reset_pin_n_in), .reset_pin_n_out(reset_pin_n_out),
  .reset_pin_oe(reset_pin_oe), .apb_req(apb_req), .pready(pready),
  .pslverr(pslverr), .irq_out(irq_out), .cpu_clk_en(cpu_clk_en),
  .port_a_lines_oe(port_a_lines_oe), .port_b_lines_oe(port_b_lines_oe),
  .port_b_pullup_en(port_b_pullup_en)
);

// File: tb.sv
// Self-checking bench for the option and remap block.
`timescale 1ns/1ns
module tb;
  import orm_pkg::*;
  logic         clk_sys;
  logic         srst;
  orm_apb_req_t req;
  logic         pready;
  logic  [31:0] prdata;
  logic         pslverr;
  logic         irq_out;
  logic         irq_pin_n;
  logic         int_reset_req;
  logic         ext_rst_n;
  logic         pin_n;
  logic         rst_n_out;
  logic         rst_oe;
  logic  [7:0]  pa_out, pa_oe, pb_in, pb_oe, pb_pu, pc_in;
  logic  [7:0]  pb_out, pc_out, pc_oe;
  logic  [5:0]  pd_oe, pd_out;
  logic         pdt_oe, pdt_out;
  logic  [31:0] rd;
  logic         er;
  int           n_mismatch;
  int           num_checks;
  logic  [13:0] wi [4] = '{LOW_WIN_FIRST, LOW_WIN_LAST,
                           UP_WIN_FIRST, UP_WIN_LAST};

  // Reset pin level: pulled up, low while either side drives it.
  assign pin_n = rst_oe ? rst_n_out : ext_rst_n;

  orm_top #(.PB_IRQ_OPT(8'h01)) u_dut (
    .clk_sys(clk_sys), .srst(srst), .apb_req(req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .irq_out(irq_out),
    .cpu_clk_en(), .irq_pin_n(irq_pin_n), .int_reset_req(int_reset_req),
    .reset_pin_n_in(pin_n), .reset_pin_n_out(rst_n_out),
    .reset_pin_oe(rst_oe), .port_a_lines_in(8'h0f),
    .port_a_lines_out(pa_out), .port_a_lines_oe(pa_oe),
    .port_b_lines_in(pb_in), .port_b_lines_out(pb_out),
    .port_b_lines_oe(pb_oe), .port_b_pullup_en(pb_pu),
    .port_c_lines_in(pc_in), .port_c_lines_out(pc_out),
    .port_c_lines_oe(pc_oe),
    .port_d_low_lines_in(6'h3f), .port_d_low_lines_out(pd_out),
    .port_d_low_lines_oe(pd_oe), .port_d_top_line_in(1'b1),
    .port_d_top_line_out(pdt_out), .port_d_top_line_oe(pdt_oe)
  );

  // Free-running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Compares one observed value with its expectation.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high or 20 cycles pass.
  task automatic apb(input logic w, input logic [13:0] i,
                     input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, w, {i, 2'b00}, {24'h0, d}};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check({31'h0, pready}, 32'h1);
    rd = prdata;
    er = pslverr;
    req <= '0;
  endtask

  // Register write.
  task automatic wr(input logic [13:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask

  // Register read against an expected byte, with no error.
  task automatic rc(input logic [13:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    check(rd, {24'h0, e});
    check({31'h0, er}, 32'h0);
  endtask

  // Idle cycles.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Waits a bounded time for the interrupt level, then compares it.
  task automatic wirq(input logic e);
    int n;
    n = 0;
    while (irq_out !== e && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    check({31'h0, irq_out}, {31'h0, e});
  endtask

  // Verdict and end of run.
  task automatic results;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #300000;
    n_mismatch++;
    results();
  end

  // Main test sequence.
  initial begin
    srst = 1'b1;
    req = '0;
    irq_pin_n = 1'b1;
    int_reset_req = 1'b0;
    ext_rst_n = 1'b1;
    pb_in = 8'hff;
    pc_in = 8'h3c;
    n_mismatch = 0;
    num_checks = 0;
    cyc(4);
    srst <= 1'b0;
    cyc(2);
    rc(IDX_OPTION, OPT_RESET);
    rc(IDX_INT_STATUS, 8'h04);
    rc(IDX_INT_STATUS, 8'h00);
    rc(IDX_PORT_D_DATA, 8'hbf);
    rc(IDX_PORT_C_DATA, 8'h3c);
    rc(IDX_PORT_A_DATA, 8'h0f);
    for (int i = 0; i < 4; i++) begin
      rc(IDX_PORT_A_DIR + 14'(i), DIR_RESET);
      rc(wi[i], ROM_FILL);
    end
    apb(1'b0, 14'h0010, 8'h00);
    check({31'h0, er}, 32'h1);
    irq_pin_n <= 1'b0;
    cyc(8);
    check({31'h0, irq_out}, 32'h0);
    wr(IDX_INT_MASK, 8'h03);
    wirq(1'b1);
    rc(IDX_INT_STATUS, 8'h01);
    rc(IDX_INT_STATUS, 8'h01);
    irq_pin_n <= 1'b1;
    cyc(6);
    rc(IDX_INT_STATUS, 8'h01);
    rc(IDX_INT_STATUS, 8'h00);
    wirq(1'b0);
    wr(IDX_OPTION, 8'h01);
    rc(IDX_OPTION, 8'h01);
    wr(IDX_OPTION, 8'h83);
    rc(IDX_OPTION, 8'h03);
    for (int i = 0; i < 4; i++) begin
      wr(wi[i], 8'h50 + 8'(i));
      rc(wi[i], 8'h50 + 8'(i));
    end
    wr(IDX_OPTION, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(wi[i], 8'h00);
      rc(wi[i], ROM_FILL);
    end
    wr(IDX_OPTION, 8'h03);
    for (int i = 0; i < 4; i++) begin
      rc(wi[i], 8'h50 + 8'(i));
    end
    irq_pin_n <= 1'b0;
    wirq(1'b1);
    rc(IDX_INT_STATUS, 8'h01);
    cyc(6);
    rc(IDX_INT_STATUS, 8'h00);
    wirq(1'b0);
    irq_pin_n <= 1'b1;
    pb_in <= 8'hfd;
    cyc(8);
    check({31'h0, irq_out}, 32'h0);
    pb_in <= 8'hfc;
    wirq(1'b1);
    rc(IDX_INT_STATUS, 8'h02);
    pb_in <= 8'hff;
    check({24'h0, pb_pu}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_PORT_A_DIR + 14'(i), 8'hff);
      rc(IDX_PORT_A_DIR + 14'(i), i == 3 ? PORT_D_MASK : 8'hff);
    end
    wr(IDX_PORT_A_DATA, 8'ha5);
    cyc(1);
    check({pa_out, pa_oe, pb_oe, 1'b0, pd_oe, pdt_oe}, 32'ha5ffff7f);
    wr(IDX_PORT_B_DATA, 8'h5a);
    wr(IDX_PORT_C_DATA, 8'hc3);
    wr(IDX_PORT_D_DATA, 8'hff);
    cyc(1);
    check({pb_out, pc_out, pc_oe, 1'b0, pd_out, pdt_out}, 32'h5ac3ff7f);
    rc(IDX_PORT_A_DATA, 8'ha5);
    rc(IDX_PORT_D_DATA, 8'hbf);
    int_reset_req <= 1'b1;
    cyc(1);
    int_reset_req <= 1'b0;
    cyc(3);
    check({30'h0, rst_oe, rst_n_out}, 32'h2);
    check({16'h0, pa_oe, pc_oe}, 32'h0);
    cyc(120);
    check({31'h0, rst_oe}, 32'h0);
    cyc(10);
    rc(IDX_OPTION, OPT_RESET);
    rc(IDX_INT_STATUS, 8'h04);
    pb_in <= 8'hfe;
    cyc(4);
    rc(IDX_INT_STATUS, 8'h02);
    rc(IDX_INT_STATUS, 8'h02);
    pb_in <= 8'hff;
    cyc(4);
    rc(IDX_INT_STATUS, 8'h02);
    rc(IDX_INT_STATUS, 8'h00);
    wr(IDX_OPTION, 8'h01);
    ext_rst_n <= 1'b0;
    cyc(6);
    ext_rst_n <= 1'b1;
    cyc(130);
    rc(IDX_OPTION, OPT_RESET);
    results();
  end
endmodule
